// >>> edr_regs.vh
/*
 event destination router: register offsets, field positions, reset values.
 assumes an avalon-mm slave with 32-bit words; each register takes one aligned word.
*/
`ifndef EDR_REGS_VH
`define EDR_REGS_VH

// ----------------------------------------------------------------
// register word indices and bus address width
// ----------------------------------------------------------------
`define EDR_IDX_CHSRC_SEL    12'hf98
`define EDR_IDX_CHSRC_DATA   12'hf99
`define EDR_IDX_DST_SEL      12'hf9a
`define EDR_IDX_DST_DATA     12'hf9b
`define EDR_IDX_CHAN_STATE   12'hf9c
`define EDR_ADDR_W           14

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define EDR_NDST             64
`define EDR_NCH              8
`define EDR_IDX_W            6
`define EDR_CHIDX_W          3
`define EDR_SRC_W            7
`define EDR_RT_W             4
`define EDR_RT_CON           3
`define EDR_RT_SEL_HI        2
`define EDR_RT_SEL_LO        0
`define EDR_TAP_CONV         4
`define EDR_TAP_TMR_HI       31
`define EDR_TAP_TMR_LO       16
`define EDR_TAP_RTC          44
`define EDR_TAP_PIN_HI       51
`define EDR_TAP_PIN_LO       48

// ----------------------------------------------------------------
// channel source codes and reset values
// ----------------------------------------------------------------
`define EDR_SRC_LOW          7'h00
`define EDR_SRC_HIGH         7'h01
`define EDR_RST_RT           4'h0
`define EDR_RST_IDX          6'h00
`define EDR_RST_CHIDX        3'h0
`define EDR_RST_SRC          7'h00

`endif

// >>> edr_router.v
/*
 event destination router: indirect per-destination routing settings and the
 64 destination outputs driven from eight event channels.
 assumes an avalon-mm master on the system clock; channel peripheral sources
 arrive as synchronous inputs, indexed by the whole 7-bit source code.
*/
// Register access over Avalon-MM is implemented here, with one wait state.
`timescale 1ns/1ps
`default_nettype none
`include "edr_regs.vh"

module edr_router
(
   input  wire        i_clk,
   input  wire        i_nrst,
   input  wire [13:0] i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [31:0] i_writedata,
   input  wire [3:0]  i_byteenable,
   input  wire [127:0] i_periph_src,
   output reg  [31:0] o_readdata,
   output reg         o_waitrequest,
   output reg         o_conv_trig,
   output reg  [15:0] o_timer_in,
   output reg         o_rtc_src,
   output reg  [3:0]  o_event_pin_output,
   output reg  [63:0] o_dst
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function hit;
      input [13:0] addr;
      input [11:0] idx;
      begin
         hit = (addr[13:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [`EDR_RT_W-1:0]    route_q [0:`EDR_NDST-1];
   reg [`EDR_SRC_W-1:0]   src_q   [0:`EDR_NCH-1];
   reg [`EDR_IDX_W-1:0]   destination_index_select_q;
   reg [`EDR_CHIDX_W-1:0] chan_index_q;
   reg [`EDR_NCH-1:0]     chan_q;
   reg                    ack_q;
   integer                k;

   wire req_w   = (i_read | i_write) & ~ack_q;
   wire wr_lane = i_write & i_byteenable[0] & ~ack_q;

   // ----------------------------------------------------------------
   // bus slave: one wait state, answer on the second edge
   // ----------------------------------------------------------------
   always @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         ack_q         <= 1'b0;
         o_waitrequest <= 1'b1;
         o_readdata    <= 32'h0000_0000;
      end
      else
      begin
         ack_q         <= req_w;
         o_waitrequest <= ~req_w;
         o_readdata    <= 32'h0000_0000;
         if (req_w & i_read)
         begin
            if (hit(i_address, `EDR_IDX_DST_SEL))
               o_readdata[`EDR_IDX_W-1:0] <= destination_index_select_q;
            else if (hit(i_address, `EDR_IDX_DST_DATA))
               o_readdata[`EDR_RT_W-1:0] <= route_q[destination_index_select_q];
            else if (hit(i_address, `EDR_IDX_CHSRC_SEL))
               o_readdata[`EDR_CHIDX_W-1:0] <= chan_index_q;
            else if (hit(i_address, `EDR_IDX_CHSRC_DATA))
               o_readdata[`EDR_SRC_W-1:0] <= src_q[chan_index_q];
            else if (hit(i_address, `EDR_IDX_CHAN_STATE))
               o_readdata[`EDR_NCH-1:0] <= chan_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes; reserved upper bits are simply not stored
   // ----------------------------------------------------------------
   always @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         destination_index_select_q <= `EDR_RST_IDX;
         chan_index_q               <= `EDR_RST_CHIDX;
         for (k = 0; k < `EDR_NDST; k = k + 1)
            route_q[k] <= `EDR_RST_RT;
         for (k = 0; k < `EDR_NCH; k = k + 1)
            src_q[k] <= `EDR_RST_SRC;
      end
      else if (wr_lane)
      begin
         if (hit(i_address, `EDR_IDX_DST_SEL))
            destination_index_select_q <= i_writedata[`EDR_IDX_W-1:0];
         else if (hit(i_address, `EDR_IDX_DST_DATA))
            route_q[destination_index_select_q] <= i_writedata[`EDR_RT_W-1:0];
         else if (hit(i_address, `EDR_IDX_CHSRC_SEL))
            chan_index_q <= i_writedata[`EDR_CHIDX_W-1:0];
         else if (hit(i_address, `EDR_IDX_CHSRC_DATA))
            src_q[chan_index_q] <= i_writedata[`EDR_SRC_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // event channels
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < `EDR_NCH; c = c + 1)
      begin : g_chan
         always @(posedge i_clk)
         begin
            if (!i_nrst)
               chan_q[c] <= 1'b0;
            else if (src_q[c] == `EDR_SRC_LOW)
               chan_q[c] <= 1'b0;
            else if (src_q[c] == `EDR_SRC_HIGH)
               chan_q[c] <= 1'b1;
            else
               chan_q[c] <= i_periph_src[src_q[c]];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // destination muxes; registered so outputs follow settings one cycle on
   // ----------------------------------------------------------------
   genvar d;
   generate
      for (d = 0; d < `EDR_NDST; d = d + 1)
      begin : g_dst
         always @(posedge i_clk)
         begin
            if (!i_nrst)
               o_dst[d] <= 1'b0;
            else if (!route_q[d][`EDR_RT_CON])
               o_dst[d] <= 1'b0;
            else
               o_dst[d] <= chan_q[route_q[d][`EDR_RT_SEL_HI:`EDR_RT_SEL_LO]];
         end
      end
   endgenerate

   // named peripheral taps, one extra register stage behind o_dst
   always @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         o_conv_trig        <= 1'b0;
         o_timer_in         <= 16'h0000;
         o_rtc_src          <= 1'b0;
         o_event_pin_output <= 4'h0;
      end
      else
      begin
         o_conv_trig        <= o_dst[`EDR_TAP_CONV];
         o_timer_in         <= o_dst[`EDR_TAP_TMR_HI:`EDR_TAP_TMR_LO];
         o_rtc_src          <= o_dst[`EDR_TAP_RTC];
         o_event_pin_output <= o_dst[`EDR_TAP_PIN_HI:`EDR_TAP_PIN_LO];
      end
   end

endmodule // edr_router
`default_nettype wire

// >>> edr_router_sva.sv
/* port assertions for the event destination router.
   assumes one clock domain, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "edr_regs.vh"
module edr_router_sva
(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic [13:0] i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic        o_conv_trig,
   input wire logic [15:0] o_timer_in,
   input wire logic        o_rtc_src,
   input wire logic [3:0]  o_event_pin_output,
   input wire logic [63:0] o_dst
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   chk_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("no answer one cycle after request");
   chk_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low too long");
   chk_rdata_idle: assert property (o_waitrequest |-> o_readdata == 32'h0)
      else $error("readdata not zero while idle");
   chk_sub_upper: assert property (i_read && !o_waitrequest
      && i_address[13:2] == `EDR_IDX_DST_DATA |-> o_readdata[31:4] == 28'h0)
      else $error("subdata upper bits set");
   chk_idx_upper: assert property (i_read && !o_waitrequest
      && i_address[13:2] == `EDR_IDX_DST_SEL |-> o_readdata[31:6] == 26'h0)
      else $error("subaddress upper bits set");
   chk_tap_conv: assert property (o_conv_trig == $past(o_dst[4]))
      else $error("converter tap mismatch");
   chk_tap_timer: assert property (o_timer_in == $past(o_dst[31:16]))
      else $error("timer tap mismatch");
   chk_tap_misc: assert property ({o_rtc_src, o_event_pin_output} ==
      $past({o_dst[44], o_dst[51:48]})) else $error("clock or pin tap mismatch");
   chk_dst_cleared: assert property ($rose(i_nrst) |-> o_dst == 64'h0 && o_waitrequest)
      else $error("outputs not cleared by reset");
   cover property (!o_waitrequest && i_write);
   cover property (!o_waitrequest && i_read);
   cover property ($rose(o_dst[63]));
endmodule // edr_router_sva
bind edr_router edr_router_sva chk_u (.i_clk, .i_nrst, .i_address, .i_read, .i_write,
   .o_readdata, .o_waitrequest, .o_conv_trig, .o_timer_in, .o_rtc_src, .o_event_pin_output,
   .o_dst);
`default_nettype wire

// >>> edr_src_model.sv
/* peripheral event sources: one source line high, picked by code.
   assumes sources are synchronous to the system clock. */
`timescale 1ns/1ps
`default_nettype none
module edr_src_model
(
   input wire logic          i_clk,
   input wire logic [6:0]    i_code,
   output var logic [127:0]  o_src = 128'h0
);
   // registered so a source change lands one edge after the bench sets it
   always @(posedge i_clk) o_src <= 128'h1 << i_code;
endmodule // edr_src_model
`default_nettype wire

// >>> edr_router_bench.sv
/* self-checking bench for the event destination router.
   assumes the avalon slave answers after one wait state. */
`timescale 1ns/1ps
`default_nettype none
`include "edr_regs.vh"
module edr_router_bench;
   logic i_clk = 0, i_nrst = 0, i_read = 0, i_write = 0, o_waitrequest, o_conv_trig, o_rtc_src;
   logic [13:0] i_address = 14'h0;
   logic [31:0] i_writedata = 32'h0, o_readdata, rd;
   logic [3:0] i_byteenable = 4'h1, o_event_pin_output;
   logic [127:0] i_periph_src;
   logic [15:0] o_timer_in;
   logic [63:0] o_dst, e;
   logic [6:0] code = 7'h0;
   logic [5:0] dst_list [0:6] = '{6'h04, 6'h10, 6'h1f, 6'h2c, 6'h30, 6'h33, 6'h3f};
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #20 i_clk = ~i_clk;
   edr_router dut_u (.i_clk, .i_nrst, .i_address, .i_read, .i_write, .i_writedata,
      .i_byteenable, .i_periph_src, .o_readdata, .o_waitrequest, .o_conv_trig, .o_timer_in,
      .o_rtc_src, .o_event_pin_output, .o_dst);
   edr_src_model src_u (.i_clk, .i_code(code), .o_src(i_periph_src));
   task automatic acc(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
      @(posedge i_clk);
      i_write <= wr;
      i_read <= !wr;
      i_address <= {idx, 2'b00};
      i_writedata <= {24'h0, wd};
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
      n_checks++;
      if (g !== x)
      begin
         $display("[ERR] %s expected %h seen %h", nm, x, g);
         n_errors++;
      end
   endtask
   task automatic route(input logic [5:0] d, input logic [3:0] v);
      acc(1, `EDR_IDX_DST_SEL, {2'b00, d});
      acc(1, `EDR_IDX_DST_DATA, {4'h0, v});
      repeat (3) @(posedge i_clk);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         n_errors++;
         stop_test;
      end
   end
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      acc(0, `EDR_IDX_DST_DATA, 8'h0);
      chk("reset route", 64'h0, rd);
      chk("reset dst", 64'h0, o_dst);
      acc(0, 12'h100, 8'h0);
      chk("unmapped read", 64'h0, rd);
      $display("test reset done");
      acc(1, `EDR_IDX_CHSRC_SEL, 8'h0);
      acc(1, `EDR_IDX_CHSRC_DATA, 8'h01);
      foreach (dst_list[i])
      begin
         e = 64'h1 << dst_list[i];
         route(dst_list[i], 4'h8);
         chk("dst on", e, o_dst);
         chk("taps", {e[4], e[31:16], e[44], e[51:48]}, {o_conv_trig, o_timer_in, o_rtc_src,
            o_event_pin_output});
         acc(0, `EDR_IDX_DST_DATA, 8'h0);
         chk("route read", 64'h8, rd);
         acc(0, `EDR_IDX_DST_SEL, 8'h0);
         chk("index read", {58'h0, dst_list[i]}, rd);
         route(dst_list[i], 4'h7);
         chk("dst off", 64'h0, o_dst);
      end
      $display("test connect done");
      for (int k = 0; k < 8; k++)
      begin
         acc(1, `EDR_IDX_CHSRC_SEL, 8'(k));
         acc(1, `EDR_IDX_CHSRC_DATA, 8'(2 + k));
      end
      for (int k = 0; k < 8; k++)
      begin
         route(6'h3f, 4'(8 + k));
         code <= 7'(2 + k);
         repeat (4) @(posedge i_clk);
         chk("sel hit", 64'h1 << 63, o_dst);
         code <= 7'(2 + (k + 1) % 8);
         repeat (4) @(posedge i_clk);
         chk("sel miss", 64'h0, o_dst);
      end
      $display("test select done");
      acc(1, `EDR_IDX_CHSRC_SEL, 8'h03);
      acc(1, `EDR_IDX_CHSRC_DATA, 8'h01);
      acc(0, `EDR_IDX_CHAN_STATE, 8'h0);
      chk("chan state", 64'h09, rd);
      route(6'h3f, 4'hb);
      chk("dst pre reset", 64'h1 << 63, o_dst);
      // mid-run reset must clear live routing, index and channel sources
      i_nrst <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      acc(0, `EDR_IDX_DST_SEL, 8'h0);
      chk("index after reset", 64'h0, rd);
      chk("dst after reset", 64'h0, o_dst);
      acc(1, `EDR_IDX_DST_SEL, 8'h3f);
      acc(0, `EDR_IDX_DST_DATA, 8'h0);
      chk("route after reset", 64'h0, rd);
      acc(0, `EDR_IDX_CHAN_STATE, 8'h0);
      chk("chan after reset", 64'h0, rd);
      $display("test reset again done");
      stop_test;
   end
endmodule // edr_router_bench
`default_nettype wire
